// ---- inc/voice_dac_defs.svh ----
`ifndef VOICE_DAC_DEFS_SVH
`define VOICE_DAC_DEFS_SVH
`define VDAC_ADDR_W 2
`define VDAC_OFS_HIGH 2'h0
`define VDAC_OFS_LOW 2'h1
`define VDAC_OFS_CTRL 2'h2
`define VDAC_BYTE_RST 8'h00
`define VDAC_ENABLE_BIT 0
`define VDAC_SETTLE_NS 1000
`define VDAC_CLK_NS 25
`define VDAC_START_CYCLES 1
`endif

// ---- inc/voice_dac_pkg.sv ----
package voice_dac_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [15:0] sample_t;
   typedef enum logic [2:0] {
      ST_OFF = 3'b001,
      ST_SETTLE = 3'b010,
      ST_READY = 3'b100
   } conv_state_t;
endpackage

// ---- inc/sample_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface sample_if;
   logic load;
   logic [15:0] word;
   modport src (output load, output word);
   modport dst (input load, input word);
endinterface
`default_nettype wire

// ---- core/voice_dac_loader_core.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "voice_dac_defs.svh"
// ================================
// Converter-facing sample latch
module voice_dac_loader_core
   import voice_dac_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   sample_if.dst smp,
   output logic [15:0] code_o,
   output logic start_o
);
   sample_t code;
   sample_t next_code;
   logic start;
   logic next_start;

   always_comb begin
      next_code = code;
      next_start = 1'b0;
      if (smp.load) begin
         next_code = smp.word;
         next_start = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         code <= {`VDAC_BYTE_RST, `VDAC_BYTE_RST};
         start <= 1'b0;
      end else begin
         code <= next_code;
         start <= next_start;
      end
   end

   assign code_o = code;
   assign start_o = start;
endmodule
`default_nettype wire

// ---- core/voice_dac_data_loader.sv ----
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "voice_dac_defs.svh"
// Overview of operation
// RULE1: Low byte write only fills the shadow buffer; converter code unchanged.
// RULE2: High byte write copies shadow to low, loads 16-bit word, starts conversion.
// RULE3: Software writes the low byte before the high byte.
// RULE4: Software enables the converter before writing new sample data.
// RULE5: Software waits the settling time after enabling before updating data.
// RULE6: Control bit 0 is enable, resets 0; bits 7..1 read zero.
// RULE7: High and low registers hold sample bits 15..8 and 7..0, reset zero.
// RULE8: Clearing enable powers the converter down.
// RULE9: Low register reads give committed low byte, not shadow contents.
module voice_dac_data_loader
   import voice_dac_pkg::*;
#(
   parameter int SETTLE_NS = `VDAC_SETTLE_NS
)(
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic NRST_I,
   // Register port
   input wire logic [`VDAC_ADDR_W-1:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [7:0] RDATA_O,
   // Converter side
   output logic [15:0] DAC_CODE_O,
   output logic DAC_START_O,
   output logic DAC_POWER_O,
   output logic DAC_SETTLED_O
);
   // ================================
   // Settling count, rounded up
   localparam int SETTLE_CYC_RAW = (SETTLE_NS + `VDAC_CLK_NS - 1) / `VDAC_CLK_NS;
   localparam int SETTLE_CYC = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
   localparam int CNT_W = $clog2(SETTLE_CYC + 1);

   function automatic logic hit(input logic [`VDAC_ADDR_W-1:0] a, input logic [`VDAC_ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   // ================================
   // Register state
   byte_t high_byte, next_high_byte;
   byte_t low_byte, next_low_byte;
   byte_t shadow, next_shadow;
   logic enable, next_enable;
   byte_t rdata, next_rdata;
   logic load;

   always_comb begin
      next_high_byte = high_byte;
      next_low_byte = low_byte;
      next_shadow = shadow;
      next_enable = enable;
      load = 1'b0;
      if (WR_I) begin
         if (hit(ADDR_I, `VDAC_OFS_LOW)) begin
            next_shadow = WDATA_I; // RULE1
         end
         if (hit(ADDR_I, `VDAC_OFS_HIGH)) begin
            next_high_byte = WDATA_I; // RULE7
            next_low_byte = shadow; // RULE2
            load = 1'b1; // RULE2
         end
         if (hit(ADDR_I, `VDAC_OFS_CTRL)) begin
            next_enable = WDATA_I[`VDAC_ENABLE_BIT]; // RULE6
         end
      end
   end

   always_comb begin
      next_rdata = `VDAC_BYTE_RST;
      if (RD_I) begin
         case (ADDR_I)
            `VDAC_OFS_HIGH: next_rdata = high_byte;
            `VDAC_OFS_LOW: next_rdata = low_byte; // RULE9
            `VDAC_OFS_CTRL: next_rdata = {7'h00, enable}; // RULE6
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         high_byte <= `VDAC_BYTE_RST; // RULE7
         low_byte <= `VDAC_BYTE_RST;
         shadow <= `VDAC_BYTE_RST;
         enable <= 1'b0;
         rdata <= `VDAC_BYTE_RST;
      end else begin
         high_byte <= next_high_byte;
         low_byte <= next_low_byte;
         shadow <= next_shadow;
         enable <= next_enable;
         rdata <= next_rdata;
      end
   end

   // ================================
   // Power and settling tracker
   // Data written before settling is still loaded; the flag only informs software timing.
   conv_state_t state, next_state;
   logic [CNT_W-1:0] cnt, next_cnt;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      case (state)
         ST_OFF: begin
            next_cnt = '0;
            if (enable) begin
               next_state = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            next_cnt = cnt + CNT_W'(1);
            if (!enable) begin
               next_state = ST_OFF; // RULE8
            end else if (cnt == CNT_W'(SETTLE_CYC - 1)) begin
               next_state = ST_READY; // RULE5
            end
         end
         ST_READY: begin
            if (!enable) begin
               next_state = ST_OFF; // RULE8
            end
         end
         default: next_state = ST_OFF;
      endcase
   end

   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         state <= ST_OFF;
         cnt <= '0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   // ================================
   // Converter word latch
   sample_if smp ();
   assign smp.load = load;
   assign smp.word = {WDATA_I, shadow}; // RULE2

   voice_dac_loader_core u_core (
      .clk_i(REF_CLK_I),
      .nrst_i(NRST_I),
      .smp(smp),
      .code_o(DAC_CODE_O),
      .start_o(DAC_START_O)
   );

   assign RDATA_O = rdata;
   assign DAC_POWER_O = enable; // RULE8
   // Gated by enable so the flag drops in the same cycle as power, not one cycle later
   assign DAC_SETTLED_O = (state == ST_READY) && enable; // RULE8
endmodule
`default_nettype wire

// ---- tb/voice_dac_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checks
module voice_dac_checker (
   input wire logic REF_CLK_I,
   input wire logic NRST_I,
   input wire logic [1:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [7:0] RDATA_O,
   input wire logic [15:0] DAC_CODE_O,
   input wire logic DAC_START_O,
   input wire logic DAC_POWER_O,
   input wire logic DAC_SETTLED_O
);
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!NRST_I);
   wire logic wh = WR_I && ADDR_I == 2'h0;
   wire logic wc = WR_I && ADDR_I == 2'h2;
   a_high_load: assert property (wh |=> DAC_START_O && DAC_CODE_O[15:8] == $past(WDATA_I))
      else $error("high write not loaded");
   a_start_cause: assert property (DAC_START_O |-> $past(wh)) else $error("stray start");
   a_code_hold: assert property (!wh |=> $stable(DAC_CODE_O)) else $error("code moved");
   a_power_set: assert property (wc |=> DAC_POWER_O == $past(WDATA_I[0])) else $error("power");
   a_power_hold: assert property (!wc |=> $stable(DAC_POWER_O)) else $error("power moved");
   a_settle_off: assert property (DAC_SETTLED_O |-> DAC_POWER_O) else $error("settled off");
   a_settle_late: assert property ($rose(DAC_POWER_O) |-> !DAC_SETTLED_O) else $error("early");
   a_ctrl_read: assert property (RD_I && ADDR_I == 2'h2 |=> RDATA_O == {7'h00, DAC_POWER_O})
      else $error("control read");
   a_high_read: assert property (RD_I && ADDR_I == 2'h0 |=> RDATA_O == DAC_CODE_O[15:8])
      else $error("high read");
   a_low_read: assert property (RD_I && ADDR_I == 2'h1 |=> RDATA_O == DAC_CODE_O[7:0])
      else $error("low read");
   cover property (wh);
   cover property ($rose(DAC_SETTLED_O));
   cover property ($fell(DAC_POWER_O));
endmodule
bind voice_dac_data_loader voice_dac_checker u_chk (.REF_CLK_I, .NRST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I,
   .RDATA_O, .DAC_CODE_O, .DAC_START_O, .DAC_POWER_O, .DAC_SETTLED_O);
`default_nettype wire

// ---- tb/voice_dac_data_loader_test.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// Register port scenarios
module voice_dac_data_loader_test import voice_dac_pkg::*;;
   logic clk = 0, nrst = 0, wr = 0, rd = 0, start, power, settled;
   logic [1:0] addr = 2'h0;
   byte_t wdata = 8'h00, rdata;
   sample_t code;
   int miscompares = 0, n_compared = 0;
   // Short settling keeps the run brief: 100 ns is four cycles
   voice_dac_data_loader #(.SETTLE_NS(100)) DUT (.REF_CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .DAC_CODE_O(code), .DAC_START_O(start),
      .DAC_POWER_O(power), .DAC_SETTLED_O(settled));
   initial forever #12.5 clk = ~clk;
   task automatic conclude;
      if (miscompares == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input sample_t got, input sample_t exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [1:0] a, input byte_t d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd_reg(input logic [1:0] a, input byte_t exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk({8'h00, rdata}, {8'h00, exp});
   endtask
   task automatic t_reset;
      rd_reg(2'h0, 8'h00);
      rd_reg(2'h1, 8'h00);
      rd_reg(2'h2, 8'h00);
   endtask
   task automatic t_enable;
      wr_reg(2'h2, 8'hFF);
      chk({14'h0, power, settled}, 16'h0002);
      rd_reg(2'h2, 8'h01);
      for (int i = 0; i < 50 && settled !== 1'b1; i++) @(posedge clk);
      if (settled !== 1'b1) begin
         miscompares++;
         conclude;
      end
   endtask
   task automatic t_commit;
      wr_reg(2'h1, 8'h34);
      chk(code, 16'h0000);
      rd_reg(2'h1, 8'h00);
      wr_reg(2'h0, 8'h12);
      chk({code[14:0], start}, 16'h2469);
      wr_reg(2'h0, 8'h56);
      chk(code, 16'h5634);
      rd_reg(2'h1, 8'h34);
      rd_reg(2'h0, 8'h56);
   endtask
   task automatic t_unmapped;
      wr_reg(2'h3, 8'hAA);
      chk(code, 16'h5634);
      rd_reg(2'h3, 8'h00);
   endtask
   task automatic t_disable;
      wr_reg(2'h2, 8'h00);
      chk({14'h0, power, settled}, 16'h0000);
      rd_reg(2'h2, 8'h00);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      t_reset;
      t_enable;
      t_commit;
      t_unmapped;
      t_disable;
      conclude;
   end
endmodule
`default_nettype wire
